// ### hw/serial_port_consts.vh
`ifndef SERIAL_PORT_CONSTS_VH
`define SERIAL_PORT_CONSTS_VH
// bits in one address or data group
`define BYTE_BITS      8
// last bit index inside a group
`define LAST_BIT       3'h7
// direction bit position in the address byte
`define DIR_BIT        7
// direction bit value that starts write cycles
`define DIR_WRITE      1'b1
// low five address bits at the end of a 32-byte page
`define PAGE_END       5'h1F
// top of the clock register space (bits 6:5)
`define CLK_SPACE      2'h0
// clock space wrap start, without direction bit
`define CLK_WRAP       7'h00
// last ram address, without direction bit
`define RAM_END        7'h7F
// ram space wrap start, without direction bit
`define RAM_WRAP       7'h20
// fifo depth default, in words
`define WQ_DEPTH       4
// strap level that selects the four-wire mode
`define STRAP_FOUR     1'b1
`endif

// ### hw/serial_port.v
// Behaviour
// R1 - four-wire mode shifts bytes MSB first
// R2 - output stays undriven until read byte ready
// R3 - first byte after select is the address
// R4 - address top bit: zero reads, one writes
// R5 - reads drive output, writes take input
// R6 - single access: one byte, then deselect
// R7 - address increments after every data byte
// R8 - clock read burst wraps 1Fh to 00h
// R9 - clock write burst wraps 9Fh to 80h
// R10 - ram read burst wraps 7Fh to 20h
// R11 - ram write burst wraps FFh to A0h
// R12 - three-wire mode shares one data line
// R13 - three-wire mode shifts bytes LSB first
// R14 - three-wire: sample rising, drive falling
// R15 - strap high four-wire, strap low three-wire
// R16 - idle clock level caught at select
// R17 - deselect ignores inputs, output undriven
// R18 - one clock per bit, eight-bit groups
// R19 - partial byte at deselect is discarded
`timescale 1ns/1ns
`include "serial_port_consts.vh"

// =====================================================
// write queue: small fifo between link and register side
module write_queue #(
  parameter WIDTH = 16,
  parameter DEPTH = `WQ_DEPTH,
  parameter AW    = 2
) (
  input  wire             clock,
  input  wire             rst_n,
  input  wire             clk_en,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1]; // storage words
  reg [AW-1:0]    wr_ptr_r;          // next slot to fill
  reg [AW-1:0]    rd_ptr_r;          // oldest slot
  reg [AW:0]      cnt_r;             // words held
  wire            push;              // accepted write
  wire            pop;               // accepted read

  assign in_ready  = (cnt_r != DEPTH[AW:0]);
  assign out_valid = (cnt_r != {(AW+1){1'b0}});
  assign out_data  = mem_r[rd_ptr_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // pointers and count, frozen while clk_en is low
  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      cnt_r    <= {(AW+1){1'b0}};
    end
    else if (clk_en)
    begin
      if (push)
      begin
        mem_r[wr_ptr_r] <= in_data;
        wr_ptr_r        <= (wr_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                              : wr_ptr_r + 1'b1;
      end
      if (pop)
        rd_ptr_r <= (rd_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                       : rd_ptr_r + 1'b1;
      if (push && !pop)
        cnt_r <= cnt_r + 1'b1;
      else if (pop && !push)
        cnt_r <= cnt_r - 1'b1;
    end
  end
endmodule

// =====================================================
// serial slave port: link side sampled on the system clock
module serial_port #(
  parameter WQ_DEPTH = `WQ_DEPTH
) (
  input  wire       clock,
  input  wire       rst_n,
  input  wire       clk_en,
  input  wire       chip_sel,
  input  wire       shift_clk,
  input  wire       serial_in_pin,
  output wire       serial_out_pin,
  output wire       serial_out_oe,
  input  wire       interface_select_strap,
  output wire       rd_req,
  output wire [7:0] rd_addr,
  input  wire       rd_ack,
  input  wire [7:0] rd_data,
  output wire       wq_valid,
  input  wire       wq_ready,
  output wire [7:0] wq_addr,
  output wire [7:0] wq_data,
  output wire       wr_drop,
  output wire       four_wire
);

  // =====================================================
  // input synchronisers
  reg [1:0] cs_sync_r;    // chip select, two flops
  reg [1:0] sck_sync_r;   // shift clock, two flops
  reg [1:0] sdi_sync_r;   // data in, two flops
  reg [1:0] strap_sync_r; // mode strap, two flops
  reg       sck_d_r;      // previous synced shift clock
  reg       cs_d_r;       // previous synced chip select

  // only the second stage of each chain is read
  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      cs_sync_r    <= 2'h0;
      sck_sync_r   <= 2'h0;
      sdi_sync_r   <= 2'h0;
      strap_sync_r <= 2'h0;
      sck_d_r      <= 1'b0;
      cs_d_r       <= 1'b0;
    end
    else if (clk_en)
    begin
      cs_sync_r    <= {cs_sync_r[0], chip_sel};
      sck_sync_r   <= {sck_sync_r[0], shift_clk};
      sdi_sync_r   <= {sdi_sync_r[0], serial_in_pin};
      strap_sync_r <= {strap_sync_r[0], interface_select_strap};
      sck_d_r      <= sck_sync_r[1];
      cs_d_r       <= cs_sync_r[1];
    end
  end

  wire cs_s    = cs_sync_r[1];          // synced select
  wire sck_s   = sck_sync_r[1];         // synced shift clock
  wire sdi_s   = sdi_sync_r[1];         // synced data in
  wire cs_rise = cs_s & ~cs_d_r;        // transfer starts
  wire sck_chg = cs_s & ~cs_rise & (sck_s != sck_d_r); // any clock edge in frame

  // =====================================================
  // transfer state
  localparam ST_ADDR = 2'h0; // taking the address byte
  localparam ST_RD   = 2'h1; // read burst
  localparam ST_WR   = 2'h2; // write burst

  reg [1:0] state_r;    // transfer phase
  reg       mode4_r;    // four-wire mode caught at select
  reg       idle_r;     // idle clock level caught at select
  reg [2:0] bit_cnt_r;  // bits taken in this group
  reg [7:0] rx_sh_r;    // incoming shift register
  reg [7:0] addr_r;     // current register or ram address
  reg       rd_req_r;   // read request to register side
  reg [7:0] tx_sh_r;    // outgoing shift register
  reg       tx_full_r;  // a read byte is loaded
  reg       oe_r;       // output pin driven
  reg       out_r;      // output pin level
  reg       push_r;     // one-cycle write into queue
  reg [15:0] push_w_r;  // address and data for queue
  reg       drop_r;     // write lost to a full queue

  // sample edge: return to idle level in four-wire, rising in three-wire
  wire samp_edge = sck_chg & (mode4_r ? (sck_s == idle_r) : sck_s);   // R14 R16
  // shift edge: leaving idle level in four-wire, falling in three-wire
  wire shft_edge = sck_chg & (mode4_r ? (sck_s != idle_r) : ~sck_s);  // R14 R16
  // next group complete on this sample edge
  wire byte_done = samp_edge & (bit_cnt_r == `LAST_BIT);              // R18
  // incoming bit placed by mode order
  wire [7:0] rx_nxt = mode4_r ? {rx_sh_r[6:0], sdi_s}                  // R1
                              : {sdi_s, rx_sh_r[7:1]};                 // R13

  // =====================================================
  // next address with page wrap, direction bit kept
  function [7:0] next_addr;
    input [7:0] a;
    begin
      if (a[6:5] == `CLK_SPACE && a[4:0] == `PAGE_END)
        next_addr = {a[`DIR_BIT], `CLK_WRAP}; // R8 R9
      else if (a[6:0] == `RAM_END)
        next_addr = {a[`DIR_BIT], `RAM_WRAP}; // R10 R11
      else
        next_addr = {a[`DIR_BIT], a[6:0] + 7'h01};
    end
  endfunction

  wire wq_in_ready; // queue can take a word

  // =====================================================
  // link state machine
  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      state_r   <= ST_ADDR;
      mode4_r   <= 1'b0;
      idle_r    <= 1'b0;
      bit_cnt_r <= 3'h0;
      rx_sh_r   <= 8'h00;
      addr_r    <= 8'h00;
      rd_req_r  <= 1'b0;
      tx_sh_r   <= 8'h00;
      tx_full_r <= 1'b0;
      oe_r      <= 1'b0;
      out_r     <= 1'b0;
      push_r    <= 1'b0;
      push_w_r  <= 16'h0000;
      drop_r    <= 1'b0;
    end
    else if (clk_en)
    begin
      push_r <= 1'b0;
      drop_r <= 1'b0;
      if (!cs_s)
      begin
        // deselected: drop frame state and read request, partial group lost, pin undriven
        state_r   <= ST_ADDR;   // R17 R19
        bit_cnt_r <= 3'h0;      // R19
        rd_req_r  <= 1'b0;
        tx_full_r <= 1'b0;
        oe_r      <= 1'b0;      // R17
      end
      else if (cs_rise)
      begin
        // new frame: catch mode and idle clock level
        mode4_r   <= (strap_sync_r[1] == `STRAP_FOUR); // R15
        idle_r    <= sck_s;                            // R16
        state_r   <= ST_ADDR;                          // R3
        bit_cnt_r <= 3'h0;
      end
      else
      begin
        // group bit counter and receive shifter
        if (samp_edge)
        begin
          bit_cnt_r <= bit_cnt_r + 3'h1; // R18
          rx_sh_r   <= rx_nxt;
        end
        // read answer loads the output shifter
        if (rd_req_r && rd_ack)
        begin
          rd_req_r  <= 1'b0;
          tx_sh_r   <= rd_data;
          tx_full_r <= 1'b1;
        end
        // drive bits only once a whole byte is loaded
        if (shft_edge && tx_full_r && state_r == ST_RD)
        begin
          oe_r    <= 1'b1;                               // R2 R5 R12
          out_r   <= mode4_r ? tx_sh_r[7] : tx_sh_r[0];  // R1 R13
          tx_sh_r <= mode4_r ? {tx_sh_r[6:0], 1'b0} : {1'b0, tx_sh_r[7:1]};
        end
        if (byte_done)
        begin
          case (state_r)
            ST_ADDR:
            begin
              // first group is the address, top bit the direction
              addr_r <= rx_nxt;                               // R3
              if (rx_nxt[`DIR_BIT] == `DIR_WRITE)
                state_r <= ST_WR;                             // R4
              else
              begin
                state_r  <= ST_RD;                            // R4
                rd_req_r <= 1'b1;                             // R5
                tx_full_r <= 1'b0;
              end
            end
            ST_RD:
            begin
              // fetch the next byte of the burst
              addr_r    <= next_addr(addr_r);                 // R7
              rd_req_r  <= 1'b1;
              tx_full_r <= 1'b0;
            end
            ST_WR:
            begin
              // whole data byte goes to the queue, or is dropped when the queue is full
              push_r   <= wq_in_ready;                        // R5
              drop_r   <= ~wq_in_ready;
              push_w_r <= {addr_r, rx_nxt};
              addr_r   <= next_addr(addr_r);                  // R7
            end
            default:
              state_r <= ST_ADDR;
          endcase
        end
      end
    end
  end

  // read request address follows the burst address
  assign rd_req  = rd_req_r;
  assign rd_addr = addr_r;

  // =====================================================
  // write queue toward the register side
  write_queue #(
    .WIDTH (16),
    .DEPTH (WQ_DEPTH),
    .AW    (2)
  ) u_wq (
    .clock     (clock),
    .rst_n     (rst_n),
    .clk_en    (clk_en),
    .in_valid  (push_r),
    .in_ready  (wq_in_ready),
    .in_data   (push_w_r),
    .out_valid (wq_valid),
    .out_ready (wq_ready),
    .out_data  ({wq_addr, wq_data})
  );

  // pin and status outputs
  assign serial_out_pin = out_r;
  assign serial_out_oe  = oe_r;     // R2 R17
  assign wr_drop        = drop_r;
  assign four_wire      = mode4_r;

endmodule

// ### tb/serial_port_assertions.sv
`timescale 1ns/1ns
// ====================
// checker: link and request timing of the serial port
module serial_port_assertions (
  input wire       clock,
  input wire       rst_n,
  input wire       chip_sel,
  input wire       interface_select_strap,
  input wire       serial_out_oe,
  input wire       rd_req,
  input wire       rd_ack,
  input wire [7:0] rd_addr,
  input wire       wq_valid,
  input wire       wr_drop,
  input wire       four_wire
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // select pin rising, then select low long enough to pass the syncs
  sequence s_sel_rise; $rose(chip_sel); endsequence
  sequence s_idle; !chip_sel [*4]; endsequence
  property p_idle_undriven; s_idle |-> !serial_out_oe; endproperty
  property p_mode_caught; s_sel_rise |-> ##5 (four_wire == interface_select_strap); endproperty
  property p_load_first; $rose(serial_out_oe) |-> !rd_req && !rd_addr[7]; endproperty
  property p_read_dir; $rose(rd_req) |-> !rd_addr[7]; endproperty
  property p_drive_read; serial_out_oe |-> !rd_addr[7]; endproperty
  property p_req_hold; rd_req && !rd_ack |=> rd_req; endproperty
  property p_ack_ends; rd_ack |=> !rd_req; endproperty
  property p_drop_full; wr_drop |-> wq_valid; endproperty
  a_idle_undriven: assert property (p_idle_undriven)
    else $error("output driven while deselected");
  a_mode_caught: assert property (p_mode_caught)
    else $error("mode differs from strap");
  a_load_first: assert property (p_load_first)
    else $error("output driven before byte loaded");
  a_read_dir: assert property (p_read_dir)
    else $error("read request with write direction");
  a_drive_read: assert property (p_drive_read)
    else $error("output driven in write cycle");
  a_req_hold: assert property (p_req_hold)
    else $error("read request dropped early");
  a_ack_ends: assert property (p_ack_ends)
    else $error("read request kept after answer");
  a_drop_full: assert property (p_drop_full)
    else $error("write dropped with room left");
endmodule

bind serial_port serial_port_assertions u_serial_port_assertions (
  .clock(clock), .rst_n(rst_n), .chip_sel(chip_sel), .rd_ack(rd_ack),
  .interface_select_strap(interface_select_strap), .serial_out_oe(serial_out_oe),
  .rd_req(rd_req), .rd_addr(rd_addr), .wq_valid(wq_valid), .wr_drop(wr_drop),
  .four_wire(four_wire)
);

// ### tb/link_master.sv
`timescale 1ns/1ns
// ====================
// far-side master: select, shift clock and outgoing data
module link_master (
  input  wire clock,
  input  wire line,
  output reg  chip_sel  = 1'b0,
  output reg  shift_clk = 1'b0,
  output reg  mosi      = 1'b0,
  output reg  mosi_oe   = 1'b0
);
  // park the clock at its idle level, then select
  task open_frame(input idle);
  begin
    @(posedge clock) shift_clk <= idle;
    repeat (4) @(posedge clock);
    chip_sel <= 1'b1;
    repeat (8) @(posedge clock);
  end
  endtask
  // deselect; data released, clock stands still
  task close_frame;
  begin
    repeat (4) @(posedge clock);
    chip_sel <= 1'b0;
    mosi_oe  <= 1'b0;
    repeat (12) @(posedge clock);
  end
  endtask
  // n bits: shift edge launches data, sample edge follows
  task xfer(input [7:0] tx, input integer n, input drive, input lsb, output [7:0] rx);
    integer i;
    integer k;
  begin
    rx = 8'h00;
    for (i = 0; i < n; i = i + 1)
    begin
      k = lsb ? i : 7 - i;
      @(posedge clock);
      shift_clk <= ~shift_clk;
      mosi      <= tx[k];
      mosi_oe   <= drive;
      repeat (3) @(posedge clock);
      @(negedge clock) rx[k] = line;
      @(posedge clock) shift_clk <= ~shift_clk;
      repeat (3) @(posedge clock);
    end
  end
  endtask
endmodule

// ### tb/rtc_serial_slave_port_bench.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin comparisons = comparisons + 1; if ((g) !== (e)) begin \
  miscompares = miscompares + 1; $display("Error %s expected %h seen %h", nm, e, g); end end
module rtc_serial_slave_port_bench;
  reg        clock       = 1'b0;
  reg        rst_n       = 1'b0;
  reg        strap       = 1'b1; // interface select strap
  reg        rd_ack      = 1'b0;
  reg  [7:0] rd_data     = 8'h00;
  reg        wq_ready    = 1'b0;
  reg        clk_en      = 1'b1; // clock enable, held high for the run
  wire       four_wire;          // mode the port caught at select
  reg        flip        = 1'b0; // pattern on an undriven line
  reg        dropped     = 1'b0; // a write byte was lost
  reg  [7:0] rx;
  integer    j;
  integer    miscompares = 0;
  integer    comparisons = 0;
  wire       cs, sck, mosi, mosi_oe, out_pin, out_oe, rd_req, wq_valid, wr_drop;
  wire [7:0] rd_addr, wq_addr, wq_data;
  wire       line = out_oe ? out_pin : mosi_oe ? mosi : flip;
  wire       sin  = strap ? (mosi_oe ? mosi : flip) : line;
  always #25 clock = ~clock;
  // register side: answer one cycle later, data from the address
  always @(posedge clock)
  begin
    flip    <= ~flip;
    rd_ack  <= rd_req && !rd_ack;
    rd_data <= rd_addr ^ 8'h5A;
    if (wr_drop === 1'b1)
      dropped <= 1'b1;
  end
  serial_port #(.WQ_DEPTH(4)) u_serial_port (
    .clock(clock), .rst_n(rst_n), .clk_en(clk_en), .chip_sel(cs), .shift_clk(sck),
    .serial_in_pin(sin), .serial_out_pin(out_pin), .serial_out_oe(out_oe),
    .interface_select_strap(strap), .rd_req(rd_req), .rd_addr(rd_addr), .rd_ack(rd_ack),
    .rd_data(rd_data), .wq_valid(wq_valid), .wq_ready(wq_ready), .wq_addr(wq_addr),
    .wq_data(wq_data), .wr_drop(wr_drop), .four_wire(four_wire)
  );
  link_master u_link_master (
    .clock(clock), .line(line), .chip_sel(cs), .shift_clk(sck), .mosi(mosi), .mosi_oe(mosi_oe)
  );
  // take one queue word and compare it
  task pop(input [7:0] ea, input [7:0] ed);
    integer t;
  begin
    t = 0;
    @(negedge clock);
    while (wq_valid !== 1'b1 && t < 40)
    begin
      @(negedge clock);
      t = t + 1;
    end
    `CHK("wq_addr", ea, wq_addr)
    `CHK("wq_data", ed, wq_data)
    @(posedge clock) wq_ready <= 1'b1;
    @(posedge clock) wq_ready <= 1'b0;
  end
  endtask
  // ram write burst past FFh while the queue stalls until full
  task t_write_fill;
  begin
    u_link_master.open_frame(1'b0);
    u_link_master.xfer(8'hFF, 8, 1'b1, 1'b0, rx);
    for (j = 0; j < 5; j = j + 1)
      u_link_master.xfer(8'h11 * (j + 1), 8, 1'b1, 1'b0, rx);
    u_link_master.close_frame;
    `CHK("wr_drop", 1'b1, dropped)
    for (j = 0; j < 4; j = j + 1)
      pop((j == 0) ? 8'hFF : 8'h9F + j, 8'h11 * (j + 1));
  end
  endtask
  // four-wire clock read burst past 1Fh, idle-high clock
  task t_read_wrap;
  begin
    u_link_master.open_frame(1'b1);
    u_link_master.xfer(8'h1F, 8, 1'b1, 1'b0, rx);
    `CHK("four_wire", 1'b1, four_wire)
    u_link_master.xfer(8'h00, 8, 1'b1, 1'b0, rx);
    `CHK("rd_byte0", 8'h1F ^ 8'h5A, rx)
    u_link_master.xfer(8'h00, 8, 1'b1, 1'b0, rx);
    `CHK("rd_byte1", 8'h00 ^ 8'h5A, rx)
    u_link_master.close_frame;
  end
  endtask
  // three-wire clock write past 9Fh, then ram read past 7Fh
  task t_three_wire;
  begin
    strap <= 1'b0;
    u_link_master.open_frame(1'b1);
    u_link_master.xfer(8'h9F, 8, 1'b1, 1'b1, rx);
    `CHK("four_wire", 1'b0, four_wire)
    u_link_master.xfer(8'hA5, 8, 1'b1, 1'b1, rx);
    u_link_master.xfer(8'h5A, 8, 1'b1, 1'b1, rx);
    u_link_master.close_frame;
    pop(8'h9F, 8'hA5);
    pop(8'h80, 8'h5A);
    u_link_master.open_frame(1'b1);
    u_link_master.xfer(8'h7F, 8, 1'b1, 1'b1, rx);
    u_link_master.xfer(8'h00, 8, 1'b0, 1'b1, rx);
    `CHK("rd_3w0", 8'h7F ^ 8'h5A, rx)
    u_link_master.xfer(8'h00, 8, 1'b0, 1'b1, rx);
    `CHK("rd_3w1", 8'h20 ^ 8'h5A, rx)
    u_link_master.close_frame;
    strap <= 1'b1;
  end
  endtask
  // deselect after half a data byte: nothing is written
  task t_partial;
  begin
    u_link_master.open_frame(1'b0);
    u_link_master.xfer(8'h80, 8, 1'b1, 1'b0, rx);
    u_link_master.xfer(8'hC3, 4, 1'b1, 1'b0, rx);
    u_link_master.close_frame;
    @(negedge clock);
    `CHK("wq_valid", 1'b0, wq_valid)
  end
  endtask
  // verdict and end of run
  task give_verdict;
  begin
    if (miscompares == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask
  initial
  begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    t_write_fill;
    t_read_wrap;
    t_three_wire;
    t_partial;
    give_verdict;
  end
  // watchdog against a hang
  initial
  begin
    repeat (20000) @(posedge clock);
    miscompares = miscompares + 1;
    give_verdict;
  end
endmodule
